//--- hw/pin_config_two_to_five.sv
// configuration, output steering and debounced status for four pads (pins 2 to 5).
// assumes register strobes, sleep and sequencing inputs, led pulse and pwm come from
// logic on the same clock; only the pad inputs and arst_n are asynchronous.
//
// Contract
// RULE1 - pin 2 bit 7 set forces the pad to an output driven low in sleep.
// RULE2 - sleep force-low acts only in sleep and only when pin 2 owns a slot.
// RULE3 - debounce select clear: 91.5 us debounce on a 30.5 us sample tick.
// RULE4 - debounce select set: 150 ms debounce on a 50 ms sample tick.
// RULE5 - bit 3 enables the pad pulldown; it resets to one.
// RULE6 - power-off reset clears pin 2 pulldown enable when pin 2 is sequenced.
// RULE7 - bit 2 picks direction, zero input, one output; resets to zero.
// RULE8 - power-off reset sets pin 2 direction to output when pin 2 is sequenced.
// RULE9 - bit 1 is read-only and returns the pad level; it reads one after reset.
// RULE10 - bit 0 holds the value driven onto an output pad; resets to zero.
// RULE11 - pin 3 bits 6:5 pick source: register value, led pulse or pwm.
// RULE12 - all four registers return to reset values on general reset.
// RULE13 - reserved bits ignore writes and read zero; input pads are never driven.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module pin_config_two_to_five
#(
  parameter int TICK_SLOW_CYC = pin_cfg_pkg::TICK_SLOW_CYC
)
(
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // power-management state
  input wire logic sleep_active,
  input wire logic pin2_in_sequence,
  input wire logic power_off_reset,
  // alternate output sources for pin 3
  input wire logic second_led_pulse,
  input wire logic pwm_out,
  // pads, index 0 is pin 2
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe_n,
  output logic [3:0] pad_pulldown
);

  localparam int SLOW_W = $clog2(TICK_SLOW_CYC);
  localparam logic [SLOW_W-1:0] TICK_SLOW_LAST = SLOW_W'(TICK_SLOW_CYC - 1);
  localparam int NP = pin_cfg_pkg::NUM_PINS;

  typedef struct packed {
    logic [NP-1:0][7:0] cfg_r;
    logic [7:0] rdata_r;
    logic [NP-1:0] out_r;
    logic [NP-1:0] oe_n_r;
    logic [NP-1:0] pd_r;
    logic [pin_cfg_pkg::FAST_W-1:0] fast_cnt_r;
    logic [SLOW_W-1:0] slow_cnt_r;
    logic tick_fast_r;
    logic tick_slow_r;
  } state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] idx;
  } hit_t;

  state_t state_r;
  state_t state_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [NP-1:0] level;
  logic [NP-1:0] sample_tick;
  hit_t wr_hit;
  hit_t rd_hit;

  // address decode shared by the write and read paths
  function automatic hit_t decode_addr(input logic [7:0] addr);
    hit_t h;
    h = '0;
    if (addr == pin_cfg_pkg::PIN2_CONFIG_ADDR)
    begin
      h = '{valid: 1'b1, idx: 2'h0};
    end
    else if (addr == pin_cfg_pkg::PIN3_CONFIG_ADDR)
    begin
      h = '{valid: 1'b1, idx: 2'h1};
    end
    else if (addr == pin_cfg_pkg::PIN4_CONFIG_ADDR)
    begin
      h = '{valid: 1'b1, idx: 2'h2};
    end
    else if (addr == pin_cfg_pkg::PIN5_CONFIG_ADDR)
    begin
      h = '{valid: 1'b1, idx: 2'h3};
    end
    return h;
  endfunction

  // reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];
  assign wr_hit = decode_addr(reg_addr);
  assign rd_hit = decode_addr(reg_addr);

  // each pin samples on the tick its debounce select asks for
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : pin_inputs
      assign sample_tick[g] = state_r.cfg_r[g][pin_cfg_pkg::DEBOUNCE_SELECT_BIT]
        ? state_r.tick_slow_r   // [RULE4]
        : state_r.tick_fast_r;  // [RULE3]
      pin_debounce u_debounce
      (
        .clock(clock),
        .rst_n(rst_n),
        .pad_raw(pad_in[g]),
        .sample_tick(sample_tick[g]),
        .level(level[g])
      );
    end
  endgenerate

  // next state of the whole block
  always_comb
  begin
    logic drive;
    logic value;
    drive = 1'b0;
    value = 1'b0;
    state_nxt = state_r;

    // tick dividers; the slow one is a parameter so simulation can shorten it
    state_nxt.tick_fast_r = 1'b0;
    if (state_r.fast_cnt_r == pin_cfg_pkg::TICK_FAST_LAST)
    begin
      state_nxt.fast_cnt_r = '0;
      state_nxt.tick_fast_r = 1'b1;  // [RULE3]
    end
    else
    begin
      state_nxt.fast_cnt_r = state_r.fast_cnt_r + pin_cfg_pkg::FAST_W'(1);
    end
    state_nxt.tick_slow_r = 1'b0;
    if (state_r.slow_cnt_r == TICK_SLOW_LAST)
    begin
      state_nxt.slow_cnt_r = '0;
      state_nxt.tick_slow_r = 1'b1;  // [RULE4]
    end
    else
    begin
      state_nxt.slow_cnt_r = state_r.slow_cnt_r + SLOW_W'(1);
    end

    // software write; the mask drops reserved and status bits
    if (reg_wr && wr_hit.valid)
    begin
      state_nxt.cfg_r[wr_hit.idx] = reg_wdata & pin_cfg_pkg::WRITE_MASK[wr_hit.idx];  // [RULE13]
    end

    // power-off reset takes over pin 2 and wins over a write in the same cycle
    if (power_off_reset && pin2_in_sequence)
    begin
      state_nxt.cfg_r[pin_cfg_pkg::PIN2_IDX][pin_cfg_pkg::PULLDOWN_ENABLE_BIT] = 1'b0;  // [RULE6]
      state_nxt.cfg_r[pin_cfg_pkg::PIN2_IDX][pin_cfg_pkg::DIR_BIT] = 1'b1;  // [RULE8]
    end

    // read data live for one cycle only, zero otherwise or when unmapped
    state_nxt.rdata_r = 8'h00;
    if (reg_rd && rd_hit.valid)
    begin
      state_nxt.rdata_r = state_r.cfg_r[rd_hit.idx];
      state_nxt.rdata_r[pin_cfg_pkg::PAD_LEVEL_BIT] = level[rd_hit.idx];  // [RULE9]
    end

    // pad steering, registered so the pins never glitch on decode
    for (int i = 0; i < NP; i++)
    begin
      drive = state_r.cfg_r[i][pin_cfg_pkg::DIR_BIT];  // [RULE7]
      value = state_r.cfg_r[i][pin_cfg_pkg::SET_BIT];  // [RULE10]
      if (i == pin_cfg_pkg::PIN3_IDX)
      begin
        // the unused code falls back to the register value
        case (pin_cfg_pkg::source_t'(state_r.cfg_r[i][pin_cfg_pkg::SEL_HI:pin_cfg_pkg::SEL_LO]))
          pin_cfg_pkg::SRC_LED_PULSE: value = second_led_pulse;  // [RULE11]
          pin_cfg_pkg::SRC_PWM: value = pwm_out;  // [RULE11]
          default: value = state_r.cfg_r[i][pin_cfg_pkg::SET_BIT];  // [RULE11]
        endcase
      end
      if (i == pin_cfg_pkg::PIN2_IDX && sleep_active && pin2_in_sequence
          && state_r.cfg_r[i][pin_cfg_pkg::SLEEP_BIT])
      begin
        drive = 1'b1;  // [RULE1] [RULE2]
        value = 1'b0;  // [RULE1]
      end
      state_nxt.out_r[i] = drive & value;  // [RULE13]
      state_nxt.oe_n_r[i] = ~drive;  // [RULE13]
      state_nxt.pd_r[i] = state_r.cfg_r[i][pin_cfg_pkg::PULLDOWN_ENABLE_BIT];  // [RULE5]
    end
  end

  // single state register; general reset restores every configuration register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r.cfg_r <= {NP{pin_cfg_pkg::CONFIG_RESET}};  // [RULE12] [RULE5] [RULE7] [RULE10]
      state_r.rdata_r <= 8'h00;
      state_r.out_r <= '0;
      state_r.oe_n_r <= '1;  // pads released as inputs
      state_r.pd_r <= '1;  // [RULE5]
      state_r.fast_cnt_r <= '0;
      state_r.slow_cnt_r <= '0;
      state_r.tick_fast_r <= 1'b0;
      state_r.tick_slow_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = state_r.rdata_r;
  assign pad_out = state_r.out_r;
  assign pad_oe_n = state_r.oe_n_r;
  assign pad_pulldown = state_r.pd_r;

endmodule

//--- hw/pin_cfg_pkg.sv
// constants for the four-pin configuration block: register map, field layout,
// reset values and debounce timing.
// assumes a 25 MHz block clock and 8-bit register accesses.
package pin_cfg_pkg;

  // block clock period in ns
  localparam int CLOCK_NS = 40;

  // register offsets, one byte register per pin
  localparam logic [7:0] PIN2_CONFIG_ADDR = 8'h62;
  localparam logic [7:0] PIN3_CONFIG_ADDR = 8'h63;
  localparam logic [7:0] PIN4_CONFIG_ADDR = 8'h64;
  localparam logic [7:0] PIN5_CONFIG_ADDR = 8'h65;
  localparam int NUM_PINS = 4;

  // field positions
  localparam int SLEEP_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 5;
  localparam int DEBOUNCE_SELECT_BIT = 4;
  localparam int PULLDOWN_ENABLE_BIT = 3;
  localparam int DIR_BIT = 2;
  localparam int PAD_LEVEL_BIT = 1;
  localparam int SET_BIT = 0;

  // index of each special pin inside the four-pin arrays
  localparam int PIN2_IDX = 0;
  localparam int PIN3_IDX = 1;

  // stored bits reset with pulldown on, everything else clear
  localparam logic [7:0] CONFIG_RESET = 8'h08;
  // pad level reads high until the debouncer has seen otherwise
  localparam logic PAD_LEVEL_RESET = 1'h1;
  // writable bits per pin, index 0 is pin 2; reserved and status bits are absent
  localparam logic [3:0][7:0] WRITE_MASK = {8'h1d, 8'h1d, 8'h7d, 8'h9d};

  // output source codes of pin 3
  typedef enum logic [1:0] {
    SRC_REGISTER = 2'h0,
    SRC_LED_PULSE = 2'h1,
    SRC_PWM = 2'h2
  } source_t;

  // debounce timing; fast figures in ns, slow ones in ms
  localparam int TICK_FAST_PS = 30500000 / 1000;  // 30.5 us expressed in ns
  localparam int DEBOUNCE_FAST_NS = 91500;
  localparam int TICK_SLOW_MS = 50;
  localparam int DEBOUNCE_SLOW_MS = 150;
  // tick periods in cycles; a least time rounds up
  localparam int TICK_FAST_CYC = (TICK_FAST_PS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TICK_SLOW_CYC = (TICK_SLOW_MS * 1000000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam int FAST_W = $clog2(TICK_FAST_CYC);
  localparam logic [FAST_W-1:0] TICK_FAST_LAST = FAST_W'(TICK_FAST_CYC - 1);
  // agreeing samples needed; both modes come to the same count
  localparam int DEBOUNCE_SAMPLES = DEBOUNCE_FAST_NS / TICK_FAST_PS;
  localparam int DEB_CNT_W = 2;

endpackage

//--- hw/pin_debounce.sv
// one-pin input synchroniser and debouncer.
// assumes sample_tick is a one-cycle enable on the block clock.
`timescale 1ns/1ns
module pin_debounce
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pad_raw,
  input wire logic sample_tick,
  output logic level
);

  typedef struct packed {
    logic sync1_r;
    logic sync2_r;
    logic [pin_cfg_pkg::DEB_CNT_W-1:0] agree_r;
    logic level_r;
  } deb_state_t;

  deb_state_t state_r;
  deb_state_t state_nxt;

  // a new level is taken only after enough ticks in a row all disagree with the old one
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sync1_r = pad_raw;
    state_nxt.sync2_r = state_r.sync1_r;
    if (sample_tick)
    begin
      if (state_r.sync2_r == state_r.level_r)
      begin
        state_nxt.agree_r = '0;
      end
      else if (state_r.agree_r == pin_cfg_pkg::DEB_CNT_W'(pin_cfg_pkg::DEBOUNCE_SAMPLES - 1))
      begin
        state_nxt.level_r = state_r.sync2_r;
        state_nxt.agree_r = '0;
      end
      else
      begin
        state_nxt.agree_r = state_r.agree_r + pin_cfg_pkg::DEB_CNT_W'(1);
      end
    end
  end

  // level starts high so the status bit reads one out of reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r.sync1_r <= 1'h0;
      state_r.sync2_r <= 1'h0;
      state_r.agree_r <= '0;
      state_r.level_r <= pin_cfg_pkg::PAD_LEVEL_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign level = state_r.level_r;

endmodule

//--- bench/pad_board_model.sv
// board side of the four pads: outside drivers, pulldowns, floating lines
// assumes pad controls from the block and drive requests from the bench
`timescale 1ns/1ns
module pad_board_model
(
  input wire logic clock,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe_n,
  input wire logic [3:0] pad_pulldown,
  input wire logic [3:0] ext_drv,
  input wire logic [3:0] ext_lvl,
  output logic [3:0] pad_in
);
  logic [3:0] flt_r = 4'h0;
  // a floating pad wanders, so a stale level never looks valid
  always_ff @(posedge clock)
    flt_r <= ~flt_r;
  // block drive wins, then the board driver, then the pulldown
  always_comb
    for (int i = 0; i < 4; i++)
      pad_in[i] = !pad_oe_n[i] ? pad_out[i]
        : ext_drv[i] ? ext_lvl[i]
        : pad_pulldown[i] ? 1'h0 : flt_r[i];
endmodule

//--- bench/pin_config_two_to_five_monitor.sv
// checker for the four-pin configuration block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
module pin_config_two_to_five_monitor
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_active,
  input wire logic pin2_in_sequence,
  input wire logic power_off_reset,
  input wire logic second_led_pulse,
  input wire logic pwm_out,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe_n,
  input wire logic [3:0] pad_pulldown
);
  logic [7:0] p2_r;
  logic [7:0] p3_r;
  logic [7:0] msk;
  logic src3;
  logic frc;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // shadow of pins 2 and 3 so pad levels can be tied to what was written
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p2_r <= 8'h08;
      p3_r <= 8'h08;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h62)
        p2_r <= reg_wdata;
      if (reg_wr && reg_addr == 8'h63)
        p3_r <= reg_wdata;
      if (power_off_reset && pin2_in_sequence)
      begin
        p2_r[3] <= 1'h0;
        p2_r[2] <= 1'h1;
      end
    end
  end
  // readable bits per address; unmapped reads nothing
  always_comb
    case (reg_addr)
      8'h62: msk = 8'h9f;
      8'h63: msk = 8'h7f;
      8'h64, 8'h65: msk = 8'h1f;
      default: msk = 8'h00;
    endcase
  // pin 3 source as selected, code 3 falls back to the register bit
  always_comb
    case (p3_r[6:5])
      2'h1: src3 = second_led_pulse;
      2'h2: src3 = pwm_out;
      default: src3 = p3_r[0];
    endcase
  assign frc = sleep_active && pin2_in_sequence && p2_r[7];
  sequence por_s;
    power_off_reset && pin2_in_sequence;
  endsequence
  AST_SLEEP_LOW: assert property (frc |=> !pad_oe_n[0] && !pad_out[0])
    else $error("pin 2 not forced low");
  AST_ACTIVE_KEEP: assert property (!frc |=> pad_oe_n[0] == !$past(p2_r[2]))
    else $error("pin 2 direction wrong");
  AST_PIN2_SET: assert property (!frc && p2_r[2] |=> pad_out[0] == $past(p2_r[0]))
    else $error("pin 2 drive value wrong");
  AST_PULL: assert property (1'b1 |=> pad_pulldown[0] == $past(p2_r[3]))
    else $error("pin 2 pulldown wrong");
  AST_POR: assert property (por_s |-> ##2 !pad_pulldown[0] && !pad_oe_n[0])
    else $error("power-off reset ignored");
  AST_PIN3_SRC: assert property (p3_r[2] |=> pad_out[1] == $past(src3))
    else $error("pin 3 source wrong");
  AST_DIR_IN: assert property (
    reg_wr && reg_addr == 8'h64 && !reg_wdata[2] |-> ##2 pad_oe_n[2] && !pad_out[2])
    else $error("input pad driven");
  AST_DRIVE: assert property (
    reg_wr && reg_addr == 8'h65 && reg_wdata[2] |-> ##2 !pad_oe_n[3] && pad_out[3] == $past(reg_wdata[0], 2))
    else $error("output pad not driven");
  AST_RSV: assert property (reg_rd |=> (reg_rdata & ~$past(msk)) == 8'h00)
    else $error("reserved bit set");
  AST_RST: assert property ($rose(arst_n) |-> pad_oe_n == 4'hf && pad_pulldown == 4'hf && pad_out == 4'h0)
    else $error("pads not at reset");
endmodule
bind pin_config_two_to_five pin_config_two_to_five_monitor i_pin_config_two_to_five_monitor (.*);

//--- bench/pin_config_two_to_five_test.sv
// self-checking bench for the four-pin configuration block
// assumes the board model beside it; slow tick shortened to keep runs brief
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("MISMATCH %0t got %h exp %h", $time, a, e); \
    end \
  end
module pin_config_two_to_five_test;
  localparam int SLOW = 50;
  localparam int FAST = pin_cfg_pkg::TICK_FAST_CYC;
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'h0, reg_rd = 1'h0, sleep_active = 1'h0, pin2_in_sequence = 1'h0;
  logic power_off_reset = 1'h0, second_led_pulse = 1'h0, pwm_out = 1'h0;
  logic [3:0] pad_in, pad_out, pad_oe_n, pad_pulldown;
  logic [3:0] ext_drv = 4'h0, ext_lvl = 4'h0;
  int err_total = 0, cmp_count = 0;
  always #20 clock = ~clock;
  pin_config_two_to_five #(.TICK_SLOW_CYC(SLOW)) i_pin_config_two_to_five (.*);
  pad_board_model i_pad_board_model (.*);
  task automatic final_report();
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  // registers at reset image, pads released with pulldown on
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h62 + 8'(i), d);
      `CHK(d, 8'h0a)
    end
    `CHK({pad_oe_n, pad_pulldown, pad_out}, 12'hff0)
  endtask
  // reserved bits ignore writes; an unmapped place stays zero
  task automatic t_rsv();
    logic [7:0] d;
    logic [7:0] exp [4] = '{8'h9f, 8'h7f, 8'h1f, 8'h1f};
    for (int i = 0; i < 4; i++)
      wr(8'h62 + 8'(i), 8'hff);
    wr(8'h61, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h62 + 8'(i), d);
      `CHK(d, exp[i])
    end
    rd(8'h61, d);
    `CHK(d, 8'h00)
    `CHK({pad_oe_n, pad_out}, 8'h0f)
  endtask
  // every pin 3 code against every mix of the three sources
  task automatic t_src();
    logic [2:0] p;
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 8; k++)
      begin
        p = 3'(k);
        wr(8'h63, {1'h0, 2'(c), 4'h6, p[0]});
        second_led_pulse <= p[1];
        pwm_out <= p[2];
        repeat (3) @(negedge clock);
        `CHK(pad_out[1], p[c == 3 ? 0 : c])
      end
  endtask
  // force-low needs the control bit, sleep and a slot all at once
  task automatic t_sleep();
    logic [2:0] s;
    for (int k = 0; k < 8; k++)
    begin
      s = 3'(k);
      wr(8'h62, {s[2], 4'h0, ~s[0], 2'h1});
      sleep_active <= s[0];
      pin2_in_sequence <= s[1];
      repeat (3) @(negedge clock);
      `CHK({pad_oe_n[0], pad_out[0]}, {s[0] && s != 3'h7, ~s[0]})
    end
  endtask
  // power-off reset on pin 2, first without a slot (no effect), then sequenced
  task automatic t_pwr();
    logic [7:0] d;
    wr(8'h62, 8'h08);
    sleep_active <= 1'h0;
    for (int q = 0; q < 2; q++)
    begin
      pin2_in_sequence <= 1'(q);
      power_off_reset <= 1'h1;
      @(posedge clock);
      power_off_reset <= 1'h0;
      rd(8'h62, d);
      `CHK(d & 8'hfd, (q != 0) ? 8'h04 : 8'h08)
      @(posedge clock);
    end
  endtask
  // a released pad must settle only after three agreeing ticks
  task automatic t_deb(input int p, input logic [7:0] c, input int t);
    logic [7:0] d;
    int n;
    wr(8'h62 + 8'(p), c);
    ext_lvl[p] <= 1'h1;
    ext_drv[p] <= 1'h1;
    d = 8'h00;
    n = 0;
    while (d[1] !== 1'h1 && n < 4 * t)
    begin
      rd(8'h62 + 8'(p), d);
      n += 2;
    end
    `CHK(d[1], 1'h1)
    if (n >= 4 * t)
      final_report();
    @(posedge clock);
    ext_drv[p] <= 1'h0;
    n = 0;
    while (d[1] !== 1'h0 && n < 4 * t)
    begin
      rd(8'h62 + 8'(p), d);
      n += 2;
    end
    `CHK(n > 2 * t && n <= 3 * t + 8, 1'h1)
    if (n >= 4 * t)
      final_report();
  endtask
  // main sequence, ending with a second reset and a repeat of the reset check
  initial
  begin
    repeat (8) @(posedge clock);
    arst_n <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    t_rsv();
    t_src();
    t_sleep();
    t_pwr();
    t_deb(2, 8'h08, FAST);
    t_deb(3, 8'h18, SLOW);
    @(posedge clock);
    arst_n <= 1'h0;
    repeat (2) @(posedge clock);
    arst_n <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    final_report();
  end
endmodule
